/* cce_exec.sv */
/*
  Decode and execute for clear-file, clear-working, clear-watchdog and
  complement-file instructions. One instruction per i_instr_valid cycle.
  Assumes the fetch logic presents the register address one cycle early on
  i_next_addr so the file operand is ready when the instruction executes.
*/
`timescale 1ns/1ps
`default_nettype none
module cce_exec
  import cce_pkg::*;
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_instr_valid,
  input  wire logic [cce_pkg::INSTR_W-1:0] i_instr,
  input  wire logic [cce_pkg::ADDR_W-1:0]  i_next_addr,
  input  wire logic                       i_presc_to_wdt,
  input  wire logic                       i_wdt_tick,
  input  wire logic                       i_presc_tick,
  input  wire logic                       i_sleep,
  output logic      [cce_pkg::DATA_W-1:0]  o_work_reg,
  output logic                            o_zero_flag,
  output logic                            o_timeout_status_bit,
  output logic                            o_powerdown_status_bit,
  output logic      [cce_pkg::WDT_W-1:0]   o_watchdog_counter,
  output logic      [cce_pkg::PRESC_W-1:0] o_prescaler,
  output logic                            o_skip_next,
  output logic                            o_done
);
  import cce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic cce_op_t decode(input logic [INSTR_W-1:0] ins);
    if (ins[11:5] == CLEAR_FILE_REG_OP_TOP) begin
      return CCE_OP_CLEAR_FILE_REG_OP;
    end else if (ins == CLEAR_WORK_REG_OP_CODE) begin
      return CCE_OP_CLEAR_WORK_REG_OP;
    end else if (ins == CLEAR_WATCHDOG_OP_CODE) begin
      return CCE_OP_CLEAR_WATCHDOG_OP;
    end else if (ins[11:6] == COMPLEMENT_FILE_REG_OP_TOP) begin
      return CCE_OP_COMPLEMENT_FILE_REG_OP;
    end
    return CCE_OP_NONE;
  endfunction

  cce_op_t                    op;
  logic    [ADDR_W-1:0]       f_addr;
  logic                       d_bit;
  logic    [DATA_W-1:0]       f_data;
  logic    [DATA_W-1:0]       comp_res;

  always_comb begin
    op       = i_instr_valid ? decode(i_instr) : CCE_OP_NONE;
    f_addr   = i_instr[ADDR_W-1:0];
    d_bit    = i_instr[D_BIT];
    comp_res = ~f_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write path
  logic                we;
  logic [DATA_W-1:0]   wdata;

  always_comb begin
    we    = 1'b0;
    wdata = ZERO_BYTE;
    unique case (op)
      CCE_OP_CLEAR_FILE_REG_OP: begin
        we    = 1'b1;
        wdata = ZERO_BYTE;
      end
      CCE_OP_COMPLEMENT_FILE_REG_OP: begin
        we    = d_bit;
        wdata = comp_res;
      end
      default: begin
        we    = 1'b0;
        wdata = ZERO_BYTE;
      end
    endcase
  end

  cce_regfile #(
    .DW (DATA_W),
    .AW (ADDR_W)
  ) u_rf (
    .i_sys_clk (i_sys_clk),
    .i_we      (we),
    .i_waddr   (f_addr),
    .i_wdata   (wdata),
    .i_raddr   (i_next_addr),
    .o_rdata   (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core state
  logic [DATA_W-1:0]  w_q,     w_d;
  logic               z_q,     z_d;
  logic               to_q,    to_d;
  logic               pd_q,    pd_d;
  logic [WDT_W-1:0]   wdt_q,   wdt_d;
  logic [PRESC_W-1:0] psc_q,   psc_d;
  logic               done_q,  done_d;

  always_comb begin
    w_d    = w_q;
    z_d    = z_q;
    to_d   = to_q;
    pd_d   = pd_q;
    wdt_d  = i_wdt_tick ? wdt_q + WDT_W'(TICK_TO_RUN) : wdt_q;
    psc_d  = i_presc_tick ? psc_q + PRESC_W'(TICK_TO_RUN) : psc_q;
    done_d = (op != CCE_OP_NONE);
    // Counter wrap is a watchdog time-out; only clear-watchdog or reset sets the bit again
    if (i_wdt_tick && (wdt_q == {WDT_W{1'b1}})) begin
      to_d = 1'b0;
    end
    if (i_sleep) begin
      pd_d = 1'b0;
    end
    unique case (op)
      CCE_OP_CLEAR_FILE_REG_OP: begin
        z_d = 1'b1;
      end
      CCE_OP_CLEAR_WORK_REG_OP: begin
        w_d = ZERO_BYTE;
        z_d = 1'b1;
      end
      CCE_OP_CLEAR_WATCHDOG_OP: begin
        wdt_d = WDT_RESET;
        if (i_presc_to_wdt) begin
          psc_d = PRESC_RESET;
        end
        to_d = 1'b1;
        pd_d = 1'b1;
      end
      CCE_OP_COMPLEMENT_FILE_REG_OP: begin
        if (!d_bit) begin
          w_d = comp_res;
        end
        z_d = (comp_res == ZERO_BYTE);
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      w_q    <= W_RESET;
      z_q    <= 1'b0;
      to_q   <= 1'b1;
      pd_q   <= 1'b1;
      wdt_q  <= WDT_RESET;
      psc_q  <= PRESC_RESET;
      done_q <= 1'b0;
    end else begin
      w_q    <= w_d;
      z_q    <= z_d;
      to_q   <= to_d;
      pd_q   <= pd_d;
      wdt_q  <= wdt_d;
      psc_q  <= psc_d;
      done_q <= done_d;
    end
  end

  // Skip is never requested by these instructions
  logic skip_q;
  always_ff @(posedge i_sys_clk) begin
    skip_q <= 1'b0;
  end

  assign o_work_reg             = w_q;
  assign o_zero_flag            = z_q;
  assign o_timeout_status_bit   = to_q;
  assign o_powerdown_status_bit = pd_q;
  assign o_watchdog_counter     = wdt_q;
  assign o_prescaler            = psc_q;
  assign o_skip_next            = skip_q;
  assign o_done                 = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_clear_work_reg_op_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_WORK_REG_OP |=> (o_work_reg == ZERO_BYTE) && o_zero_flag)
    else $error("clear-working did not zero W and set Z");
  a_clear_file_reg_op_zflag: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_FILE_REG_OP |=> o_zero_flag)
    else $error("clear-file did not set Z");
  a_wdt_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_WATCHDOG_OP |=> o_watchdog_counter == WDT_RESET)
    else $error("watchdog counter not cleared");
  a_presc_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_WATCHDOG_OP && i_presc_to_wdt |=> o_prescaler == PRESC_RESET)
    else $error("prescaler not cleared");
  a_presc_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_WATCHDOG_OP && !i_presc_to_wdt && !i_presc_tick
      |=> o_prescaler == $past(o_prescaler))
    else $error("prescaler changed while owned by timer");
  a_status_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_CLEAR_WATCHDOG_OP |=> o_timeout_status_bit && o_powerdown_status_bit
      && o_zero_flag == $past(o_zero_flag))
    else $error("clear-watchdog status bits wrong");
  a_complement_file_reg_op_zflag: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_COMPLEMENT_FILE_REG_OP |=> o_zero_flag == ($past(f_data) == 8'hFF))
    else $error("complement zero flag wrong");
  a_complement_file_reg_op_to_w: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_COMPLEMENT_FILE_REG_OP && !d_bit |=> o_work_reg == ~$past(f_data))
    else $error("complement to W wrong");
  a_complement_file_reg_op_keep_w: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op == CCE_OP_COMPLEMENT_FILE_REG_OP && d_bit |=> o_work_reg == $past(o_work_reg))
    else $error("complement to file disturbed W");
  a_one_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    op != CCE_OP_NONE |=> o_done && !o_skip_next)
    else $error("instruction not done in one cycle");
endmodule // cce_exec
`default_nettype wire

/* cce_pkg.sv */
/*
  Package for the clear/complement execute block: opcodes, fields, reset values.
  Assumes a 12-bit instruction word and an 8-bit data path.
*/
package cce_pkg;
  localparam int          INSTR_W       = 12;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 5;
  localparam int          REGS          = 32;
  localparam int          PRESC_W       = 8;
  localparam int          WDT_W         = 8;
  localparam int          D_BIT         = 5;
  localparam logic [6:0]  CLEAR_FILE_REG_OP_TOP      = 7'h03;
  localparam logic [11:0] CLEAR_WORK_REG_OP_CODE     = 12'h040;
  localparam logic [11:0] CLEAR_WATCHDOG_OP_CODE   = 12'h004;
  localparam logic [5:0]  COMPLEMENT_FILE_REG_OP_TOP      = 6'h09;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [7:0]  WDT_RESET     = 8'h00;
  localparam logic [7:0]  PRESC_RESET   = 8'h00;
  localparam int          TICK_TO_RUN   = 1;
  typedef enum logic [2:0] {
    CCE_OP_NONE,
    CCE_OP_CLEAR_FILE_REG_OP,
    CCE_OP_CLEAR_WORK_REG_OP,
    CCE_OP_CLEAR_WATCHDOG_OP,
    CCE_OP_COMPLEMENT_FILE_REG_OP
  } cce_op_t;
endpackage

/* cce_regfile.sv */
/*
  Small file-register memory with one write port and a registered read port.
  Assumes the read address is presented one cycle before the data is used.
*/
`timescale 1ns/1ps
`default_nettype none
module cce_regfile #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    // Write-through so a back-to-back read sees fresh data
    if (i_we && (i_waddr == i_raddr)) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // cce_regfile
`default_nettype wire

/* tb_clear_complement_instr_exec.sv */
/*
  Self-checking testbench for cce_exec: one task for each instruction scenario.
  Assumes cce_pkg, a 100 MHz clock and file operand addresses held one cycle ahead.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_clear_complement_instr_exec;
  import cce_pkg::*;
  logic                i_sys_clk      = 1'b0;
  logic                i_rstn         = 1'b0;
  logic                i_instr_valid  = 1'b0;
  logic [INSTR_W-1:0]  i_instr        = 12'h000;
  logic [ADDR_W-1:0]   i_next_addr    = 5'h0A;
  logic                i_presc_to_wdt = 1'b0;
  logic                i_wdt_tick     = 1'b0;
  logic                i_presc_tick   = 1'b0;
  logic                i_sleep        = 1'b0;
  logic [DATA_W-1:0]   o_work_reg;
  logic                o_zero_flag;
  logic                o_timeout_status_bit;
  logic                o_powerdown_status_bit;
  logic [WDT_W-1:0]    o_watchdog_counter;
  logic [PRESC_W-1:0]  o_prescaler;
  logic                o_skip_next;
  logic                o_done;
  int                  errors         = 0;
  int                  cmp_count      = 0;
  // Address held constant so the registered read always matches the operand
  localparam logic [4:0] FA = 5'h0A;

  always #5 i_sys_clk = ~i_sys_clk;

  cce_exec u_dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_next_addr(i_next_addr), .i_presc_to_wdt(i_presc_to_wdt),
    .i_wdt_tick(i_wdt_tick), .i_presc_tick(i_presc_tick), .i_sleep(i_sleep),
    .o_work_reg(o_work_reg), .o_zero_flag(o_zero_flag),
    .o_timeout_status_bit(o_timeout_status_bit),
    .o_powerdown_status_bit(o_powerdown_status_bit),
    .o_watchdog_counter(o_watchdog_counter), .o_prescaler(o_prescaler),
    .o_skip_next(o_skip_next), .o_done(o_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic issue(input logic [11:0] ins);
    @(posedge i_sys_clk);
    i_instr       <= ins;
    i_instr_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    #1;
    chk("done", 8'h01, {7'h00, o_done});
    chk("skip", 8'h00, {7'h00, o_skip_next});
  endtask

  task automatic t_clear_work_reg_op();
    issue({CLEAR_FILE_REG_OP_TOP, FA});
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b0, FA});
    chk("work", 8'hFF, o_work_reg);
    issue(CLEAR_WORK_REG_OP_CODE);
    chk("work", 8'h00, o_work_reg);
    chk("zero", 8'h01, {7'h00, o_zero_flag});
    $display("test clear_work_reg_op finished");
  endtask

  task automatic t_complement_file_reg_op();
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b1, FA});
    chk("work", 8'h00, o_work_reg);
    chk("zero", 8'h00, {7'h00, o_zero_flag});
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b0, FA});
    chk("work", 8'h00, o_work_reg);
    chk("zero", 8'h01, {7'h00, o_zero_flag});
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b0, FA});
    chk("work", 8'h00, o_work_reg);
    $display("test complement_file_reg_op finished");
  endtask

  task automatic t_clear_file_reg_op();
    // File holds FF here; two complements back into it keep FF and leave zero flag clear
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b1, FA});
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b1, FA});
    chk("zero", 8'h00, {7'h00, o_zero_flag});
    issue({CLEAR_FILE_REG_OP_TOP, FA});
    chk("zero", 8'h01, {7'h00, o_zero_flag});
    issue({COMPLEMENT_FILE_REG_OP_TOP, 1'b0, FA});
    chk("work", 8'hFF, o_work_reg);
    chk("zero", 8'h00, {7'h00, o_zero_flag});
    $display("test clear_file_reg_op finished");
  endtask

  // Ticks land three times before each clear; zero flag stays 0 from the last test
  task automatic t_wdt(input logic own, input logic [7:0] presc_exp);
    @(posedge i_sys_clk);
    i_presc_to_wdt <= own;
    i_sleep        <= 1'b1;
    i_wdt_tick     <= 1'b1;
    i_presc_tick   <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    i_sleep        <= 1'b0;
    i_wdt_tick     <= 1'b0;
    i_presc_tick   <= 1'b0;
    #1;
    chk("powerdown", 8'h00, {7'h00, o_powerdown_status_bit});
    chk("counter", 8'h03, o_watchdog_counter);
    issue(CLEAR_WATCHDOG_OP_CODE);
    chk("counter", 8'h00, o_watchdog_counter);
    chk("prescaler", presc_exp, o_prescaler);
    chk("timeout", 8'h01, {7'h00, o_timeout_status_bit});
    chk("powerdown", 8'h01, {7'h00, o_powerdown_status_bit});
    chk("zero", 8'h00, {7'h00, o_zero_flag});
    $display("test clear watchdog finished");
  endtask

  // A full wrap of the watchdog counter is a time-out; clear-watchdog must undo it
  task automatic t_timeout();
    @(posedge i_sys_clk);
    i_wdt_tick <= 1'b1;
    repeat (2**WDT_W) @(posedge i_sys_clk);
    i_wdt_tick <= 1'b0;
    #1;
    chk("timeout", 8'h00, {7'h00, o_timeout_status_bit});
    issue(CLEAR_WATCHDOG_OP_CODE);
    chk("timeout", 8'h01, {7'h00, o_timeout_status_bit});
    chk("powerdown", 8'h01, {7'h00, o_powerdown_status_bit});
    $display("test watchdog time-out finished");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    t_clear_work_reg_op();
    t_complement_file_reg_op();
    t_clear_file_reg_op();
    t_wdt(1'b0, 8'h03);
    t_wdt(1'b1, 8'h00);
    t_timeout();
    tally_and_finish();
  end

  // Whole run needs well under 500 cycles
  initial begin
    repeat (2000) @(posedge i_sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule // tb_clear_complement_instr_exec
`default_nettype wire
